// ===== lsar_pkg.sv
package lsar_pkg;

   // Register port widths
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Attribute register offsets (register port byte addresses)
   localparam logic [7:0] OFF_ATTR_BIOS_F_SEGMENT = 8'h59;
   localparam logic [7:0] OFF_ATTR_C0_C4_SEGMENTS = 8'h5a;
   localparam logic [7:0] OFF_ATTR_C8_CC_SEGMENTS = 8'h5b;
   localparam logic [7:0] OFF_ATTR_D0_D4_SEGMENTS = 8'h5c;
   localparam logic [7:0] OFF_ATTR_D8_DC_SEGMENTS = 8'h5d;
   localparam logic [7:0] OFF_ATTR_E0_E4_SEGMENTS = 8'h5e;
   localparam logic [7:0] OFF_ATTR_E8_EC_SEGMENTS = 8'h5f;
   localparam int unsigned NUM_ATTR_REGS          = 7;
   localparam int unsigned NUM_SEGMENTS           = 13;

   // Block control and status registers
   localparam logic [7:0] OFF_ROUTE_CONTROL = 8'h56;
   localparam logic [7:0] OFF_ROUTE_STATUS  = 8'h57;

   // Field layout within an attribute register
   localparam int unsigned FIELD_W       = 4;
   localparam int unsigned READ_CLAIM_LO = 0;
   localparam int unsigned WRITE_CLAIM_LO = 1;
   localparam int unsigned READ_CLAIM_HI = 4;
   localparam int unsigned WRITE_CLAIM_HI = 5;
   localparam logic [7:0] ATTR_WMASK_FULL = 8'h33;
   localparam logic [7:0] ATTR_WMASK_BIOS = 8'h30;
   localparam logic [7:0] ATTR_RESET      = 8'h00;

   // Control register fields
   localparam int unsigned CTRL_LOW_HOLE_BIT  = 0;
   localparam int unsigned CTRL_VIDEO_SMM_BIT = 1;
   localparam logic [7:0]  CTRL_WMASK         = 8'h03;
   localparam logic [7:0]  CTRL_RESET         = 8'h00;

   // Address map boundaries (20-bit legacy window)
   localparam int unsigned HADDR_W        = 32;
   localparam logic [31:0] DOS_LOW_LAST   = 32'h0007ffff;
   localparam logic [31:0] DOS_HOLE_LAST  = 32'h0009ffff;
   localparam logic [31:0] VIDEO_LAST     = 32'h000bffff;
   localparam logic [31:0] EXPANSION_LAST = 32'h000effff;
   localparam logic [31:0] LEGACY_LAST    = 32'h000fffff;
   localparam int unsigned SEG_IDX_LSB    = 14;
   localparam int unsigned SEG_IDX_W      = 4;

   typedef enum logic [1:0] {
      SRC_HOST,
      SRC_HUB,
      SRC_AGP,
      SRC_PCI
   } lsar_source_type;

   typedef enum logic [1:0] {
      DEST_MEMORY,
      DEST_HUB_LINK_A,
      DEST_NONE
   } lsar_dest_type;

   typedef struct packed {
      logic                  valid;
      logic                  write;
      lsar_source_type       source;
      logic                  system_management_mode;
      logic [HADDR_W-1:0]    addr;
   } lsar_access_type;

   typedef struct packed {
      logic          valid;
      lsar_dest_type dest;
      logic          claimed;
      logic          blocked;
   } lsar_route_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } lsar_regreq_type;

endpackage

// ===== lsar_router.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module lsar_router (
   input  wire logic                    CLK_SYS,
   input  wire logic                    RST,
   input  wire lsar_pkg::lsar_regreq_type REG_REQ,
   output      logic [lsar_pkg::DATA_W-1:0] REG_RDATA,
   input  wire lsar_pkg::lsar_access_type ACCESS,
   output      lsar_pkg::lsar_route_type  ROUTE
);

   logic [lsar_pkg::DATA_W-1:0] attr_reg [lsar_pkg::NUM_ATTR_REGS];
   logic [lsar_pkg::DATA_W-1:0] ctrl_reg;
   logic [lsar_pkg::DATA_W-1:0] rdata_next;
   logic [lsar_pkg::DATA_W-1:0] status_next;
   lsar_pkg::lsar_route_type    route_reg;
   lsar_pkg::lsar_route_type    route_next;
   logic                        read_claim;
   logic                        write_claim;
   logic [lsar_pkg::SEG_IDX_W-1:0] seg_idx;
   logic [lsar_pkg::DATA_W-1:0] seg_reg;

   // Attribute registers, one per offset
   genvar gi;
   generate
      for (gi = 0; gi < lsar_pkg::NUM_ATTR_REGS; gi++) begin : g_attr
         localparam logic [7:0] OFF = lsar_pkg::OFF_ATTR_BIOS_F_SEGMENT + 8'(gi);
         localparam logic [7:0] MSK = (gi == 0) ? lsar_pkg::ATTR_WMASK_BIOS
                                                : lsar_pkg::ATTR_WMASK_FULL;
         always_ff @(posedge CLK_SYS or posedge RST) begin
            if (RST) begin
               attr_reg[gi] <= lsar_pkg::ATTR_RESET;
            end else if (REG_REQ.wr && REG_REQ.addr == OFF) begin
               attr_reg[gi] <= REG_REQ.wdata & MSK;
            end
         end
      end
   endgenerate

   // Control register
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ctrl_reg <= lsar_pkg::CTRL_RESET;
      end else if (REG_REQ.wr && REG_REQ.addr == lsar_pkg::OFF_ROUTE_CONTROL) begin
         ctrl_reg <= REG_REQ.wdata & lsar_pkg::CTRL_WMASK;
      end
   end

   // Status shows last routing decision
   always_comb begin
      status_next = '0;
      status_next[1:0] = route_reg.dest;
      status_next[2] = route_reg.claimed;
      status_next[3] = route_reg.blocked;
   end

   // Read data, one cycle after the strobe
   always_comb begin
      rdata_next = '0;
      if (REG_REQ.addr == lsar_pkg::OFF_ROUTE_CONTROL) begin
         rdata_next = ctrl_reg;
      end else if (REG_REQ.addr == lsar_pkg::OFF_ROUTE_STATUS) begin
         rdata_next = status_next;
      end else begin
         for (int i = 0; i < lsar_pkg::NUM_ATTR_REGS; i++) begin
            if (REG_REQ.addr == lsar_pkg::OFF_ATTR_BIOS_F_SEGMENT + 8'(i)) begin
               rdata_next = attr_reg[i];
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         REG_RDATA <= '0;
      end else if (REG_REQ.rd) begin
         REG_RDATA <= rdata_next;
      end else begin
         REG_RDATA <= '0;
      end
   end

   // Segment attribute lookup
   always_comb begin
      seg_idx = ACCESS.addr[lsar_pkg::SEG_IDX_LSB +: lsar_pkg::SEG_IDX_W];
      seg_reg = '0;
      read_claim = 1'b0;
      write_claim = 1'b0;
      if (ACCESS.addr > lsar_pkg::EXPANSION_LAST) begin
         read_claim  = attr_reg[0][lsar_pkg::READ_CLAIM_HI];
         write_claim = attr_reg[0][lsar_pkg::WRITE_CLAIM_HI];
      end else begin
         if (seg_idx[3:1] < 3'(lsar_pkg::NUM_ATTR_REGS - 1)) begin
            seg_reg = attr_reg[1 + 32'(seg_idx[3:1])];
         end
         if (seg_idx[0]) begin
            read_claim  = seg_reg[lsar_pkg::READ_CLAIM_HI];
            write_claim = seg_reg[lsar_pkg::WRITE_CLAIM_HI];
         end else begin
            read_claim  = seg_reg[lsar_pkg::READ_CLAIM_LO];
            write_claim = seg_reg[lsar_pkg::WRITE_CLAIM_LO];
         end
      end
   end

   // Routing decision
   always_comb begin
      route_next = '0;
      route_next.valid = ACCESS.valid;
      route_next.dest = lsar_pkg::DEST_MEMORY;
      route_next.claimed = 1'b1;
      if (ACCESS.addr <= lsar_pkg::DOS_LOW_LAST) begin
         route_next.dest = lsar_pkg::DEST_MEMORY;
      end else if (ACCESS.addr <= lsar_pkg::DOS_HOLE_LAST) begin
         if (ctrl_reg[lsar_pkg::CTRL_LOW_HOLE_BIT]) begin
            route_next.dest = lsar_pkg::DEST_HUB_LINK_A;
            route_next.claimed = 1'b0;
         end
      end else if (ACCESS.addr <= lsar_pkg::VIDEO_LAST) begin
         if (ACCESS.source != lsar_pkg::SRC_HOST) begin
            if (ctrl_reg[lsar_pkg::CTRL_VIDEO_SMM_BIT]) begin
               route_next.dest = lsar_pkg::DEST_NONE;
               route_next.claimed = 1'b0;
               route_next.blocked = 1'b1;
            end else begin
               route_next.dest = lsar_pkg::DEST_HUB_LINK_A;
               route_next.claimed = 1'b0;
            end
         end else if (!(ACCESS.system_management_mode
                        && ctrl_reg[lsar_pkg::CTRL_VIDEO_SMM_BIT])) begin
            route_next.dest = lsar_pkg::DEST_HUB_LINK_A;
            route_next.claimed = 1'b0;
         end
      end else if (ACCESS.addr <= lsar_pkg::LEGACY_LAST) begin
         if (ACCESS.source != lsar_pkg::SRC_HOST) begin
            route_next.dest = lsar_pkg::DEST_MEMORY;
         end else if ((ACCESS.write && !write_claim)
                      || (!ACCESS.write && !read_claim)) begin
            route_next.dest = lsar_pkg::DEST_HUB_LINK_A;
            route_next.claimed = 1'b0;
         end else begin
            route_next.dest = lsar_pkg::DEST_MEMORY;
         end
      end
      if (!ACCESS.valid) begin
         route_next.dest = lsar_pkg::DEST_NONE;
         route_next.claimed = 1'b0;
         route_next.blocked = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         route_reg <= '{valid: 1'b0, dest: lsar_pkg::DEST_NONE, claimed: 1'b0, blocked: 1'b0};
      end else begin
         route_reg <= route_next;
      end
   end

   assign ROUTE = route_reg;

endmodule // lsar_router

// ===== lsar_initiator.sv
`timescale 1ns/1ps
// Access initiator for any source (host, hub, AGP, PCI), one cycle from request to bus
module lsar_initiator (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire lsar_pkg::lsar_access_type req,
   output      lsar_pkg::lsar_access_type access
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         access <= '0;
      end else begin
         access <= req;
      end
   end
endmodule // lsar_initiator

// ===== lsar_router_chk.sv
`timescale 1ns/1ps
module lsar_router_chk (
   input wire logic                      CLK_SYS,
   input wire logic                      RST,
   input wire lsar_pkg::lsar_regreq_type REG_REQ,
   input wire logic [7:0]                REG_RDATA,
   input wire lsar_pkg::lsar_access_type ACCESS,
   input wire lsar_pkg::lsar_route_type  ROUTE
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   sequence s_wr_rd;
      REG_REQ.wr && REG_REQ.addr inside {[8'h59:8'h5f]} ##1
      REG_REQ.rd && REG_REQ.addr == $past(REG_REQ.addr);
   endsequence
   a_wr_rd_mask:
      assert property (s_wr_rd |=> REG_RDATA == ($past(REG_REQ.wdata, 2) &
         ($past(REG_REQ.addr, 2) == 8'h59 ? 8'h30 : 8'h33))) else $error("masked readback");
   a_rdata_idle:
      assert property (!$past(REG_REQ.rd) |-> REG_RDATA == 8'h00) else $error("rdata not zero");
   a_bios_low_rsvd:
      assert property (REG_REQ.rd && REG_REQ.addr == 8'h59 |=> REG_RDATA[3:0] == 4'h0)
         else $error("bios low field");
   a_low_dos_mem:
      assert property (ACCESS.valid && ACCESS.addr <= 32'h0007ffff |=> ROUTE.valid &&
         ROUTE.dest == lsar_pkg::DEST_MEMORY && ROUTE.claimed) else $error("low area");
   a_nonhost_mem:
      assert property (ACCESS.valid && ACCESS.source != lsar_pkg::SRC_HOST &&
         ACCESS.addr inside {[32'h000c0000:32'h000fffff]} |=> ROUTE.dest == lsar_pkg::DEST_MEMORY)
         else $error("non-host access");
   a_video_host_io:
      assert property (ACCESS.valid && ACCESS.source == lsar_pkg::SRC_HOST &&
         !ACCESS.system_management_mode && ACCESS.addr inside {[32'h000a0000:32'h000bffff]}
         |=> ROUTE.dest == lsar_pkg::DEST_HUB_LINK_A && !ROUTE.claimed) else $error("video");
   a_idle_none:
      assert property (!ACCESS.valid |=> !ROUTE.valid && ROUTE.dest == lsar_pkg::DEST_NONE)
         else $error("idle route");
   a_claim_mem:
      assert property (ROUTE.valid |-> ROUTE.claimed == (ROUTE.dest == lsar_pkg::DEST_MEMORY))
         else $error("claim mismatch");
endmodule // lsar_router_chk
bind lsar_router lsar_router_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .REG_REQ(REG_REQ),
   .REG_RDATA(REG_RDATA), .ACCESS(ACCESS), .ROUTE(ROUTE));

// ===== legacy_segment_attribute_router_tb_top.sv
`timescale 1ns/1ps
module legacy_segment_attribute_router_tb_top;
   localparam lsar_pkg::lsar_source_type H = lsar_pkg::SRC_HOST;
   localparam logic [4:0] MEM = {1'b1, lsar_pkg::DEST_MEMORY, 2'b10};
   localparam logic [4:0] HUB = {1'b1, lsar_pkg::DEST_HUB_LINK_A, 2'b00};
   localparam logic [4:0] BLK = {1'b1, lsar_pkg::DEST_NONE, 2'b01};
   logic                      clk_sys;
   logic                      rst;
   lsar_pkg::lsar_regreq_type req;
   logic [7:0]                rdata;
   logic [7:0]                rv;
   lsar_pkg::lsar_access_type areq;
   lsar_pkg::lsar_access_type acc;
   lsar_pkg::lsar_route_type  route;
   int                        failures;
   int                        checks_done;
   lsar_initiator u_init (.clk(clk_sys), .rst(rst), .req(areq), .access(acc));
   lsar_router dut (.CLK_SYS(clk_sys), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
      .ACCESS(acc), .ROUTE(route));
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      req.rd <= 1'b0;
      @(negedge clk_sys);
      rv = rdata;
   endtask
   task automatic wr_rd(logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      req.rd <= 1'b0;
      @(negedge clk_sys);
      rv = rdata;
   endtask
   task automatic go(logic w, lsar_pkg::lsar_source_type s, logic m, logic [31:0] a,
                     logic [4:0] e);
      @(posedge clk_sys);
      areq <= '{valid: 1'b1, write: w, source: s, system_management_mode: m, addr: a};
      @(posedge clk_sys);
      areq.valid <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("route", {3'h0, route.valid, route.dest, route.claimed, route.blocked}, {3'h0, e});
   endtask
   task automatic t_regs();
      for (int i = 0; i < 7; i++) begin
         rd(8'h59 + i[7:0]);
         check("reset", rv, 8'h00);
         wr_rd(8'h59 + i[7:0], 8'hff);
         check("mask", rv, i == 0 ? 8'h30 : 8'h33);
         wr(8'h59 + i[7:0], 8'h00);
      end
      rd(8'h60);
      check("unmapped", rv, 8'h00);
      $display("regs done");
   endtask
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         wr(8'h5a, 8'hcc | m[7:0]);
         go(1'b0, H, 1'b0, 32'h000c0000, m[0] ? MEM : HUB);
         go(1'b1, H, 1'b0, 32'h000c3fff, m[1] ? MEM : HUB);
      end
      $display("modes done");
   endtask
   task automatic t_map();
      logic [31:0] a;
      logic [31:0] c;
      for (int s = 0; s < 13; s++) begin
         a = s == 12 ? 32'h000f0000 : 32'h000c0000 + s * 32'h4000;
         c = s == 12 ? 32'h000c0000 : (s[0] ? a - 32'h4000 : a + 32'h4000);
         wr(s == 12 ? 8'h59 : 8'h5a + s[7:0] / 2, (s[0] || s == 12) ? 8'h30 : 8'h03);
         go(1'b0, H, 1'b0, a, MEM);
         go(1'b1, H, 1'b0, a + 32'h3fff, MEM);
         go(1'b0, H, 1'b0, c, HUB);
         go(1'b0, lsar_pkg::SRC_HUB, 1'b0, a, MEM);
      end
      $display("map done");
   endtask
   task automatic t_fixed();
      wr_rd(8'h56, 8'hff);
      check("control", rv, 8'h03);
      go(1'b0, H, 1'b0, 32'h0007ffff, MEM);
      go(1'b1, H, 1'b0, 32'h00080000, HUB);
      go(1'b0, H, 1'b1, 32'h000a0000, MEM);
      go(1'b0, lsar_pkg::SRC_AGP, 1'b0, 32'h000bffff, BLK);
      wr(8'h56, 8'h00);
      go(1'b0, H, 1'b0, 32'h0009ffff, MEM);
      go(1'b0, H, 1'b1, 32'h000bffff, HUB);
      rd(8'h57);
      check("status", rv, 8'h02);
      $display("fixed done");
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      rst = 1'b1;
      req = '0;
      areq = '0;
      failures = 0;
      checks_done = 0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_modes();
      t_map();
      t_fixed();
      end_of_test();
   end
   initial begin
      #100000;
      failures++;
      end_of_test();
   end
endmodule // legacy_segment_attribute_router_tb_top
